// >>> pkg/cc_array_pkg.sv
package cc_array_pkg;
    // =====================================================================
    // Register map (plain port, byte-wide registers).
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam logic [4:0] OFF_CONTROL = 5'h00;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h01;
    localparam logic [4:0] OFF_CNT_LOW = 5'h02;
    localparam logic [4:0] OFF_CNT_HIGH = 5'h03;
    localparam logic [4:0] OFF_TICK_DIV = 5'h04;
    localparam logic [4:0] OFF_MODE_BASE = 5'h08;
    localparam logic [4:0] OFF_CAP_LOW_BASE = 5'h10;
    localparam logic [4:0] OFF_CAP_HIGH_BASE = 5'h18;
    // =====================================================================
    // Field positions of module_mode_reg.
    localparam int B_IRQ_EN = 0;
    localparam int B_PWM_EN = 1;
    localparam int B_TOGGLE = 2;
    localparam int B_MATCH = 3;
    localparam int B_CAP_FALL = 4;
    localparam int B_CAP_RISE = 5;
    localparam int B_CMP_EN = 6;
    // Control register: bit 7 runs the counter, low bits are the event flags.
    localparam int B_RUN = 7;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hff;
    localparam logic [7:0] DIV_DEFAULT = 8'h00;
endpackage

// >>> verilog/cc_tick_div.sv
`timescale 1ns/1ns
module cc_tick_div
    import cc_array_pkg::*;
(
    input wire logic sys_clk_i, // System clock.
    input wire logic rst_b_i, // Async reset, active low.
    input wire logic run_i, // Counting allowed.
    input wire logic [7:0] div_i, // Ticks come every div_i+1 clocks.
    output logic tick_o // One-cycle tick enable.
);
    logic [7:0] cnt_r, cnt_nxt;
    logic tick_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        if (!run_i) begin
            cnt_nxt = RST_BYTE;
        end else if (cnt_r >= div_i) begin
            cnt_nxt = RST_BYTE;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 8'h01;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= RST_BYTE;
            tick_o <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_o <= tick_nxt;
        end
    end
endmodule

// >>> verilog/cc_module.sv
`timescale 1ns/1ns
module cc_module
    import cc_array_pkg::*;
(
    input wire logic sys_clk_i, // System clock.
    input wire logic rst_b_i, // Async reset, active low.
    input wire logic [7:0] mode_i, // module_mode_reg contents.
    input wire logic [15:0] count_i, // Shared counter value.
    input wire logic tick_i, // Counter advances after this cycle.
    input wire logic pin_i, // Sampled module_io_pin level.
    input wire logic cap_low_we_i, // Software write of capture_low_byte.
    input wire logic cap_high_we_i, // Software write of capture_high_byte.
    input wire logic [7:0] wdata_i, // Software write data.
    output logic [7:0] cap_low_o, // capture_low_byte.
    output logic [7:0] cap_high_o, // capture_high_byte.
    output logic pin_o, // module_io_pin drive level.
    output logic event_o // One-cycle match or capture event.
);
    logic [7:0] low_r, low_nxt, high_r, high_nxt;
    logic pin_r, pin_nxt, prev_r, ev_r, ev_nxt;
    logic match, rise, fall, capture;

    assign match = tick_i && mode_i[B_CMP_EN] && (count_i == {high_r, low_r});
    assign rise = pin_i && !prev_r;
    assign fall = !pin_i && prev_r;
    assign capture = (rise && mode_i[B_CAP_RISE]) || (fall && mode_i[B_CAP_FALL]);

    always_comb begin
        low_nxt = low_r;
        high_nxt = high_r;
        pin_nxt = pin_r;
        ev_nxt = 1'b0;
        if (cap_low_we_i) begin
            low_nxt = wdata_i;
        end
        if (cap_high_we_i) begin
            high_nxt = wdata_i;
        end
        if (capture) begin
            low_nxt = count_i[7:0];
            high_nxt = count_i[15:8];
            ev_nxt = 1'b1;
        end
        if (mode_i[B_PWM_EN] && mode_i[B_CMP_EN]) begin
            pin_nxt = (count_i[7:0] >= low_r);
            if (tick_i && count_i[7:0] == BYTE_MAX) begin
                low_nxt = high_r;
            end
        end else if (match) begin
            if (mode_i[B_TOGGLE]) begin
                pin_nxt = !pin_r;
            end
            if (mode_i[B_MATCH]) begin
                ev_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            low_r <= RST_BYTE;
            high_r <= RST_BYTE;
            pin_r <= 1'b1;
            prev_r <= 1'b1;
            ev_r <= 1'b0;
        end else begin
            low_r <= low_nxt;
            high_r <= high_nxt;
            pin_r <= pin_nxt;
            prev_r <= pin_i;
            ev_r <= ev_nxt;
        end
    end

    assign cap_low_o = low_r;
    assign cap_high_o = high_r;
    assign pin_o = pin_r;
    assign event_o = ev_r;
endmodule

// >>> verilog/cc_array_top.sv
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
// What this block does
// - Each of five modules has a mode register.
// - Interrupt enable lets the event flag interrupt.
// - Toggle bit inverts pin on counter match.
// - Match bit sets event flag on match.
// - Capture edges chosen: falling, rising, or both.
// - Comparator works only while comparator enabled.
// - Valid pin edge copies counter into capture.
// - Interrupt needs both event flag and enable.
// - All PWM outputs share one counter.
// - PWM low below duty byte, else high.
// - Low byte wrap reloads duty from high byte.
module cc_array_top
    import cc_array_pkg::*;
#(
    parameter int N_MOD = 5
) (
    input wire logic sys_clk_i, // System clock, 50 MHz.
    input wire logic rst_b_i, // Async reset, active low.
    input wire logic [ADDR_W-1:0] addr_i, // Register address.
    input wire logic [DATA_W-1:0] wdata_i, // Write data.
    input wire logic wr_i, // Write strobe.
    input wire logic rd_i, // Read strobe.
    output logic [DATA_W-1:0] rdata_o, // Read data, cycle after rd_i.
    input wire logic [N_MOD-1:0] pin_i, // module_io_pin input levels.
    output logic [N_MOD-1:0] pin_o, // module_io_pin output levels.
    output logic [N_MOD-1:0] pin_oe_o, // High while module drives its pin.
    output logic irq_o // Level interrupt.
);
    // =====================================================================
    // Register state.
    logic [7:0] mode_r [N_MOD];
    logic [7:0] mode_nxt [N_MOD];
    logic [N_MOD-1:0] flag_r, flag_nxt, mask_r, mask_nxt;
    logic run_r, run_nxt;
    logic [15:0] count_r, count_nxt;
    logic [7:0] div_r, div_nxt;
    logic [7:0] rdata_nxt;
    logic irq_nxt;
    logic [N_MOD-1:0] pin_oe_nxt;
    logic tick;
    logic [N_MOD-1:0] events, pin_mod;
    logic [7:0] cap_low [N_MOD];
    logic [7:0] cap_high [N_MOD];
    logic [N_MOD-1:0] we_low, we_high;

    cc_tick_div u_div (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .run_i(run_r),
        .div_i(div_r),
        .tick_o(tick)
    );

    // =====================================================================
    // Modules.
    for (genvar g = 0; g < N_MOD; g++) begin : g_mod
        assign we_low[g] = wr_i && (addr_i == OFF_CAP_LOW_BASE + ADDR_W'(g));
        assign we_high[g] = wr_i && (addr_i == OFF_CAP_HIGH_BASE + ADDR_W'(g));
        cc_module u_mod (
            .sys_clk_i(sys_clk_i),
            .rst_b_i(rst_b_i),
            .mode_i(mode_r[g]),
            .count_i(count_r),
            .tick_i(tick),
            .pin_i(pin_i[g]),
            .cap_low_we_i(we_low[g]),
            .cap_high_we_i(we_high[g]),
            .wdata_i(wdata_i),
            .cap_low_o(cap_low[g]),
            .cap_high_o(cap_high[g]),
            .pin_o(pin_mod[g]),
            .event_o(events[g])
        );
    end

    // =====================================================================
    // Next-state logic.
    always_comb begin
        count_nxt = count_r;
        div_nxt = div_r;
        run_nxt = run_r;
        mask_nxt = mask_r;
        flag_nxt = flag_r;
        rdata_nxt = RST_BYTE;
        for (int i = 0; i < N_MOD; i++) begin
            mode_nxt[i] = mode_r[i];
            pin_oe_nxt[i] = mode_r[i][B_CMP_EN] && (mode_r[i][B_TOGGLE] || mode_r[i][B_PWM_EN]);
        end
        if (tick) begin
            count_nxt = count_r + 16'h0001;
        end
        if (wr_i) begin
            if (addr_i == OFF_CONTROL) begin
                run_nxt = wdata_i[B_RUN];
                // Write one to clear a flag.
                flag_nxt = flag_r & ~wdata_i[N_MOD-1:0];
            end
            if (addr_i == OFF_IRQ_MASK) begin
                mask_nxt = wdata_i[N_MOD-1:0];
            end
            if (addr_i == OFF_CNT_LOW) begin
                count_nxt[7:0] = wdata_i;
            end
            if (addr_i == OFF_CNT_HIGH) begin
                count_nxt[15:8] = wdata_i;
            end
            if (addr_i == OFF_TICK_DIV) begin
                div_nxt = wdata_i;
            end
            for (int i = 0; i < N_MOD; i++) begin
                if (addr_i == OFF_MODE_BASE + ADDR_W'(i)) begin
                    mode_nxt[i] = {1'b0, wdata_i[6:0]};
                end
            end
        end
        // Hardware set wins over a clear in the same cycle.
        flag_nxt = flag_nxt | events;
        if (rd_i) begin
            if (addr_i == OFF_CONTROL) begin
                rdata_nxt = 8'(flag_r) | ({7'h00, run_r} << B_RUN);
            end
            if (addr_i == OFF_IRQ_MASK) begin
                rdata_nxt = 8'(mask_r);
            end
            if (addr_i == OFF_CNT_LOW) begin
                rdata_nxt = count_r[7:0];
            end
            if (addr_i == OFF_CNT_HIGH) begin
                rdata_nxt = count_r[15:8];
            end
            if (addr_i == OFF_TICK_DIV) begin
                rdata_nxt = div_r;
            end
            for (int i = 0; i < N_MOD; i++) begin
                if (addr_i == OFF_MODE_BASE + ADDR_W'(i)) begin
                    rdata_nxt = mode_r[i];
                end
                if (addr_i == OFF_CAP_LOW_BASE + ADDR_W'(i)) begin
                    rdata_nxt = cap_low[i];
                end
                if (addr_i == OFF_CAP_HIGH_BASE + ADDR_W'(i)) begin
                    rdata_nxt = cap_high[i];
                end
            end
        end
        irq_nxt = 1'b0;
        for (int i = 0; i < N_MOD; i++) begin
            // Interrupt enable lives in each mode register; mask gates it too.
            if (flag_r[i] && mode_r[i][B_IRQ_EN] && mask_r[i]) begin
                irq_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < N_MOD; i++) begin
                mode_r[i] <= RST_BYTE;
            end
            flag_r <= '0;
            mask_r <= '0;
            run_r <= 1'b0;
            count_r <= 16'h0000;
            div_r <= DIV_DEFAULT;
            rdata_o <= RST_BYTE;
            irq_o <= 1'b0;
            pin_oe_o <= '0;
            pin_o <= '1;
        end else begin
            mode_r <= mode_nxt;
            flag_r <= flag_nxt;
            mask_r <= mask_nxt;
            run_r <= run_nxt;
            count_r <= count_nxt;
            div_r <= div_nxt;
            rdata_o <= rdata_nxt;
            irq_o <= irq_nxt;
            pin_oe_o <= pin_oe_nxt;
            pin_o <= pin_mod;
        end
    end

    // =====================================================================
    // Checks.
    property p_irq_cause;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        irq_o |-> $past(|(flag_r & mask_r));
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without flag");

    property p_flag_sticky;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (flag_r[0] && !(wr_i && addr_i == OFF_CONTROL && wdata_i[0])) |=> flag_r[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

    property p_event_sets;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        events[0] |=> flag_r[0];
    endproperty
    a_event_sets: assert property (p_event_sets) else $error("event not flagged");

    property p_count_step;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (tick && !wr_i) |=> count_r == $past(count_r) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter step");

    property p_no_cmp;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (!mode_r[0][B_CMP_EN] && !mode_r[0][B_CAP_FALL] && !mode_r[0][B_CAP_RISE]) |=> !events[0];
    endproperty
    a_no_cmp: assert property (p_no_cmp) else $error("event while off");

    property p_pwm_level;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (mode_r[0][B_PWM_EN] && mode_r[0][B_CMP_EN] && $stable(mode_r[0]))
            |=> ##1 pin_o[0] == ($past(count_r[7:0], 2) >= $past(cap_low[0], 2));
    endproperty
    a_pwm_level: assert property (p_pwm_level) else $error("pwm level");

    property p_reload;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (mode_r[0][B_PWM_EN] && mode_r[0][B_CMP_EN] && tick && count_r[7:0] == BYTE_MAX
            && !mode_r[0][B_CAP_FALL] && !mode_r[0][B_CAP_RISE])
            |=> cap_low[0] == $past(cap_high[0]);
    endproperty
    a_reload: assert property (p_reload) else $error("duty reload");

    property p_count_hold;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (!tick && !wr_i) |=> count_r == $past(count_r);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("counter moved");

    property p_tick_stop;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        !run_r |=> !tick;
    endproperty
    a_tick_stop: assert property (p_tick_stop) else $error("tick while stopped");

    // =====================================================================
    // Per-module checks; every module is watched, since scenarios use different ones.
    for (genvar a = 0; a < N_MOD; a++) begin : g_chk
        property p_toggle;
            @(posedge sys_clk_i) disable iff (!rst_b_i)
            (tick && mode_r[a] == 8'h4c && count_r == {cap_high[a], cap_low[a]})
                |=> ##1 pin_o[a] != $past(pin_o[a]);
        endproperty
        a_toggle: assert property (p_toggle) else $error("no toggle");

        // Outside PWM a pin changes only through a toggle match.
        property p_pin_hold;
            @(posedge sys_clk_i) disable iff (!rst_b_i)
            (!mode_r[a][B_PWM_EN] && !(tick && mode_r[a][B_CMP_EN] && mode_r[a][B_TOGGLE]))
                |=> ##1 pin_o[a] == $past(pin_o[a]);
        endproperty
        a_pin_hold: assert property (p_pin_hold) else $error("pin moved");

        property p_match_flag;
            @(posedge sys_clk_i) disable iff (!rst_b_i)
            (tick && mode_r[a][B_CMP_EN] && mode_r[a][B_MATCH] && !mode_r[a][B_PWM_EN]
                && count_r == {cap_high[a], cap_low[a]})
                |=> ##1 flag_r[a];
        endproperty
        a_match_flag: assert property (p_match_flag) else $error("match not flagged");

        // Only an event raises a flag, so a flag never appears on its own.
        property p_flag_rise;
            @(posedge sys_clk_i) disable iff (!rst_b_i)
            (!flag_r[a] && !events[a]) |=> !flag_r[a];
        endproperty
        a_flag_rise: assert property (p_flag_rise) else $error("flag without event");

        // A capture in PWM mode may be overwritten by the duty reload, so PWM is left out.
        property p_cap_load;
            @(posedge sys_clk_i) disable iff (!rst_b_i)
            (!mode_r[a][B_PWM_EN]
                && ((mode_r[a][B_CAP_RISE] && pin_i[a] && !$past(pin_i[a]))
                || (mode_r[a][B_CAP_FALL] && !pin_i[a] && $past(pin_i[a]))))
                |=> {cap_high[a], cap_low[a]} == $past(count_r);
        endproperty
        a_cap_load: assert property (p_cap_load) else $error("capture value");

        property p_irq_level;
            @(posedge sys_clk_i) disable iff (!rst_b_i)
            (flag_r[a] && mode_r[a][B_IRQ_EN] && mask_r[a]) |=> irq_o;
        endproperty
        a_irq_level: assert property (p_irq_level) else $error("irq missing");

        property p_mode_read;
            @(posedge sys_clk_i) disable iff (!rst_b_i)
            (rd_i && addr_i == OFF_MODE_BASE + ADDR_W'(a)) |=> rdata_o == $past(mode_r[a]);
        endproperty
        a_mode_read: assert property (p_mode_read) else $error("mode readback");

        property p_pwm_drive;
            @(posedge sys_clk_i) disable iff (!rst_b_i)
            (mode_r[a][B_PWM_EN] && mode_r[a][B_CMP_EN]) |=> pin_oe_o[a];
        endproperty
        a_pwm_drive: assert property (p_pwm_drive) else $error("pwm pin not driven");
    end
endmodule

// >>> dv/cc_pin_model.sv
`timescale 1ns/1ns
// ====
// Far side of the module pins; a pin the block drives wins over it.
module cc_pin_model (
    input wire logic sys_clk_i, // System clock.
    input wire logic [4:0] drv_i, // Levels driven by the block.
    input wire logic [4:0] oe_i, // Block drive enables.
    output logic [4:0] wire_o // Resolved pin levels.
);
    logic [4:0] lvl_r = 5'h00;
    assign wire_o = (oe_i & drv_i) | (~oe_i & lvl_r);
    // Edges are launched just after a clock edge so the block never sees a race.
    task automatic set_pin(input int n, input logic v);
        @(posedge sys_clk_i);
        lvl_r[n] <= v;
    endtask
endmodule

// >>> dv/counter_array_capture_compare_tb.sv
`timescale 1ns/1ns
module counter_array_capture_compare_tb;
    import cc_array_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic [4:0] pin_w;
    logic [4:0] pin_o;
    logic [4:0] pin_oe_o;
    logic irq_o;
    logic [7:0] rd_v;
    int fails = 0;
    int checked = 0;
    cc_array_top #(.N_MOD(5)) dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .pin_i(pin_w), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .irq_o(irq_o));
    cc_pin_model drv (.sys_clk_i(sys_clk_i), .drv_i(pin_o), .oe_i(pin_oe_o), .wire_o(pin_w));
    initial begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    // ====
    // Bus tasks and comparison.
    task automatic end_sim();
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 rd_v = rdata_o;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    // ====
    // Scenarios.
    task automatic t_reset();
        chk("pin_o", 8'h1f, {3'h0, pin_o});
        chk("pin_oe", 8'h00, {3'h0, pin_oe_o});
        chk("irq", 8'h00, {7'h00, irq_o});
        rd(OFF_CONTROL);
        chk("control", 8'h00, rd_v);
        wr(5'h1f, 8'hff);
        rd(5'h1f);
        chk("unmapped", 8'h00, rd_v);
        wr(5'(OFF_MODE_BASE + 4), 8'hff);
        rd(5'(OFF_MODE_BASE + 4));
        chk("mode4", 8'h7f, rd_v);
    endtask
    // The counter is stopped, so a capture must return exactly the written count.
    task automatic t_capture();
        logic [7:0] modes [3] = '{8'h10, 8'h20, 8'h30};
        logic [7:0] want;
        for (int i = 0; i < 3; i++) begin
            wr(5'(OFF_MODE_BASE + i), modes[i]);
            wr(OFF_CONTROL, 8'h1f);
            wr(OFF_CNT_HIGH, 8'h12);
            wr(OFF_CNT_LOW, 8'(8'h30 + i));
            drv.set_pin(i, 1'b1);
            wait_clk(12);
            want = modes[i][B_CAP_RISE] ? 8'(8'h30 + i) : 8'h00;
            rd(5'(OFF_CAP_LOW_BASE + i));
            chk("cap_low rise", want, rd_v);
            rd(OFF_CONTROL);
            chk("flag rise", {7'h00, modes[i][B_CAP_RISE]}, {7'h00, rd_v[i]});
            wr(OFF_CONTROL, 8'h1f);
            wr(OFF_CNT_LOW, 8'(8'h40 + i));
            drv.set_pin(i, 1'b0);
            wait_clk(5);
            if (modes[i][B_CAP_FALL]) begin
                want = 8'(8'h40 + i);
            end
            rd(5'(OFF_CAP_LOW_BASE + i));
            chk("cap_low fall", want, rd_v);
            rd(5'(OFF_CAP_HIGH_BASE + i));
            chk("cap_high", 8'h12, rd_v);
            rd(OFF_CONTROL);
            chk("flag fall", {7'h00, modes[i][B_CAP_FALL]}, {7'h00, rd_v[i]});
        end
    endtask
    task automatic t_irq();
        wr(OFF_CONTROL, 8'h1f);
        wr(OFF_MODE_BASE, 8'h31);
        drv.set_pin(0, 1'b1);
        wait_clk(6);
        chk("irq masked", 8'h00, {7'h00, irq_o});
        wr(OFF_IRQ_MASK, 8'h01);
        wait_clk(3);
        chk("irq raised", 8'h01, {7'h00, irq_o});
        wr(OFF_MODE_BASE, 8'h30);
        wait_clk(3);
        chk("irq no enable", 8'h00, {7'h00, irq_o});
        wr(OFF_MODE_BASE, 8'h31);
        wait_clk(3);
        chk("irq held", 8'h01, {7'h00, irq_o});
        wr(OFF_CONTROL, 8'h01);
        wait_clk(3);
        chk("irq cleared", 8'h00, {7'h00, irq_o});
    endtask
    // Count runs from 0x0010 past 0x0020 once; without the comparator nothing happens.
    task automatic t_match();
        logic [7:0] modes [2] = '{8'h08, 8'h4c};
        wr(5'(OFF_CAP_LOW_BASE + 3), 8'h20);
        for (int k = 0; k < 2; k++) begin
            wr(5'(OFF_MODE_BASE + 3), modes[k]);
            wr(OFF_CONTROL, 8'h1f);
            wr(OFF_CNT_HIGH, 8'h00);
            wr(OFF_CNT_LOW, 8'h10);
            wr(OFF_CONTROL, 8'h80);
            wait_clk(30);
            wr(OFF_CONTROL, 8'h00);
            rd(OFF_CONTROL);
            chk("match flag", 8'(k), {7'h00, rd_v[3]});
            chk("toggle pin", 8'(1 - k), {7'h00, pin_o[3]});
            chk("toggle oe", 8'(k), {7'h00, pin_oe_o[3]});
        end
    endtask
    task automatic t_pwm();
        logic [7:0] lows [3] = '{8'h85, 8'h7f, 8'h80};
        logic [1:0] want [3] = '{2'b01, 2'b00, 2'b01};
        wr(OFF_MODE_BASE, 8'h42);
        wr(5'(OFF_MODE_BASE + 1), 8'h42);
        wr(OFF_CAP_LOW_BASE, 8'h80);
        wr(5'(OFF_CAP_LOW_BASE + 1), 8'h90);
        wr(OFF_CNT_HIGH, 8'h00);
        for (int k = 0; k < 3; k++) begin
            wr(OFF_CNT_LOW, lows[k]);
            wait_clk(4);
            chk("pwm pins", {6'h00, want[k]}, {6'h00, pin_o[1:0]});
        end
        chk("pwm oe", 8'h03, {6'h00, pin_oe_o[1:0]});
        wr(OFF_CAP_HIGH_BASE, 8'h40);
        wr(OFF_CNT_LOW, 8'hff);
        wr(OFF_CONTROL, 8'h80);
        wait_clk(4);
        wr(OFF_CONTROL, 8'h00);
        rd(OFF_CAP_LOW_BASE);
        chk("duty reload", 8'h40, rd_v);
        rd(OFF_CNT_HIGH);
        chk("count carry", 8'h01, rd_v);
        // With a divider of three the counter steps once every four clocks.
        wr(OFF_TICK_DIV, 8'h03);
        rd(OFF_TICK_DIV);
        chk("tick div", 8'h03, rd_v);
        wr(OFF_CNT_LOW, 8'h00);
        wr(OFF_CONTROL, 8'h80);
        wait_clk(15);
        wr(OFF_CONTROL, 8'h00);
        rd(OFF_CNT_LOW);
        chk("count divided", 8'h04, rd_v);
    endtask
    // ====
    // Main sequence and watchdog.
    initial begin
        repeat (10) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        wait_clk(1);
        t_reset();
        t_capture();
        t_irq();
        t_match();
        t_pwm();
        end_sim();
    end
    // The tests need well under a thousand cycles; the margin covers a slow design.
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fails++;
        end_sim();
    end
endmodule
